// >>> ufc_cfg.svh
/*
 * constants of the uart register control core: register offsets, field positions,
 * reset values and fifo, counter and buffer sizes.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

`define UFC_OFF_ISR_FCR   3'h2
`define UFC_OFF_LCR       3'h3
`define UFC_OFF_THR       3'h0
`define UFC_OFF_TRG       3'h7

`define UFC_FCR_RESET     8'h00
`define UFC_LCR_RESET     8'h00
`define UFC_TRG_RESET     8'h01

`define UFC_FCR_EN        0
`define UFC_FCR_RXRST     1
`define UFC_FCR_TXRST     2
`define UFC_FCR_WAKE      3
`define UFC_FCR_TXT_LO    4
`define UFC_FCR_RXT_LO    6

`define UFC_FIFO_DEPTH    128
`define UFC_CNT_W         8
`define UFC_BUF_DEPTH     2

`endif

// >>> ufc_pkg.sv
/*
 * types of the uart register control core.
 * assumes ufc_cfg.svh is on the include path.
 */
`include "ufc_cfg.svh"

package ufc_pkg;

    typedef enum logic [1:0] {
        UFC_TBL_A = 2'b00,
        UFC_TBL_B = 2'b01,
        UFC_TBL_C = 2'b10,
        UFC_TBL_D = 2'b11
    } ufc_table_t;

    typedef enum logic [1:0] {
        UFC_SEL_NONE = 2'b00,
        UFC_SEL_READ = 2'b01,
        UFC_SEL_WRITE = 2'b10
    } ufc_state_t;

    // register access request from the host bus front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ufc_req_t;

    // pending interrupt sources, from the rest of the uart
    typedef struct packed {
        logic lineStatus;
        logic rxTimeout;
        logic modemStatus;
        logic charMatch;
        logic flowPinRise;
        logic wakeUp;
        logic gpioPending;
    } ufc_src_t;

    // decoded line format
    typedef struct packed {
        logic [3:0] wordBits;
        logic       stopLong;
        logic       stopHalf;
        logic       parityEn;
        logic       parityVal;
        logic       parityForced;
        logic       parityEven;
    } ufc_fmt_t;

endpackage

// >>> ufc_buf.sv
/*
 * two-entry buffer with valid and ready on both sides, holding read data.
 * assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "ufc_cfg.svh"

module ufc_buf (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       inValid,
    output logic            inReady,
    input  wire logic [7:0] inData,
    output logic            outValid,
    input  wire logic       outReady,
    output logic [7:0]      outData
);
    import ufc_pkg::*;

    logic [7:0] mem_r [`UFC_BUF_DEPTH];
    logic       wp_r;
    logic       rp_r;
    logic [1:0] cnt_r;
    wire        push = inValid && inReady;
    wire        pop  = outValid && outReady;

    assign inReady  = (cnt_r != 2'(`UFC_BUF_DEPTH));
    assign outValid = (cnt_r != 2'h0);
    assign outData  = mem_r[rp_r];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r  <= wp_r ^ push;
            rp_r  <= rp_r ^ pop;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // ufc_buf

// >>> ufc_core.sv
/*
 * register control core of a uart: interrupt status, fifo control, line control.
 * assumes a host bus front end delivering one-cycle read and write strobes,
 * and uart datapath logic reporting fifo levels and interrupt sources.
 */
`timescale 1ns/100ps
`include "ufc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - status bit 0 low while an interrupt is pending, high otherwise
// - status bits 3:1 carry the highest pending source
// - priority codes: line, timeout, rx ready, tx ready, modem, match, flow
// - status read clears tx ready, char match and wake-up; data write clears tx ready only
// - bit 4 shows character match when enhanced functions are on
// - bit 5 shows flow pin rising edge when enhanced functions are on
// - bit 7 shows fifos enabled
// - bit 6 equals bit 7 unless a gpio interrupt is pending with gpioIntEnable set, then inverted
// - fifo control bit 0 enables fifos and gates every other bit
// - bit 1 pulses a receive fifo pointer reset
// - bit 2 pulses a transmit fifo pointer reset
// - bit 3 enables wake-up interrupt, only with enhanced functions
// - tx interrupt below trigger, or empty if reload never passed it or fifos are disabled
// - rx interrupt, with fifos enabled, once receive level reaches the selected trigger
// - with enhanced functions off, the receive trigger selection governs both directions
// - table a: receive 1,4,8,14; transmit 1
// - tables b and c give their fixed receive and transmit levels
// - table d takes levels from the programmable trigger register
// - line bits 1:0 select 5 to 8 data bits
// - line bit 2 selects one, one and half or two stop bits
// - line bit 3 enables parity generation and checking
// - line bit 4 picks odd at 0, even at 1
// - line bit 5 forces parity to the inverse of bit 4
module ufc_core (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire ufc_pkg::ufc_req_t req,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic [7:0]            rdData,
    output logic                  reqReady,
    input  wire logic             enhancedEn,
    input  wire logic [1:0]       featureTable,
    input  wire logic             featureTrgTx,
    input  wire logic             gpioIntEnable,
    input  wire ufc_pkg::ufc_src_t src,
    input  wire logic [7:0]       rxLevel,
    input  wire logic [7:0]       txLevel,
    output logic                  rxFifoReset,
    output logic                  txFifoReset,
    output logic                  fifoEnable,
    output logic                  wakeIntEnable,
    output logic [7:0]            rxTrigger,
    output logic [7:0]            txTrigger,
    output logic                  rxReadyIrq,
    output logic                  txReadyIrq,
    output ufc_pkg::ufc_fmt_t     lineFormat
);
    import ufc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic [7:0] lineCtl_r;
    logic       fifoEn_r;
    logic       wakeEn_r;
    logic [1:0] rxSel_r;
    logic [1:0] txSel_r;
    logic [7:0] trgRx_r;
    logic [7:0] trgTx_r;
    logic       rxRst_r;
    logic       txRst_r;
    logic       txIrq_r;
    logic       matchIrq_r;
    logic       wakeIrq_r;
    logic       reloadOver_r;
    logic [7:0] txLevelPrev_r;
    ufc_state_t lastAcc_r;

    wire wrFcr = req.wr && (req.addr == `UFC_OFF_ISR_FCR) && reqReady;
    wire wrLcr = req.wr && (req.addr == `UFC_OFF_LCR);
    wire wrThr = req.wr && (req.addr == `UFC_OFF_THR);
    wire wrTrg = req.wr && (req.addr == `UFC_OFF_TRG);
    wire rdIsr = req.rd && (req.addr == `UFC_OFF_ISR_FCR) && reqReady;
    wire rdLcr = req.rd && (req.addr == `UFC_OFF_LCR);
    wire rdAny = req.rd && reqReady;

    wire fcrTakes = wrFcr && req.wdata[`UFC_FCR_EN];

    ////////////////////////////////////////////////////////////////////////////
    // trigger tables

    ufc_table_t tbl;
    assign tbl = ufc_table_t'(featureTable);

    wire [7:0] rxA = (rxSel_r == 2'h0) ? 8'h01 : (rxSel_r == 2'h1) ? 8'h04 :
                     (rxSel_r == 2'h2) ? 8'h08 : 8'h0E;
    wire [7:0] rxB = (rxSel_r == 2'h0) ? 8'h08 : (rxSel_r == 2'h1) ? 8'h10 :
                     (rxSel_r == 2'h2) ? 8'h18 : 8'h1C;
    wire [7:0] txB = (txSel_r == 2'h0) ? 8'h10 : (txSel_r == 2'h1) ? 8'h08 :
                     (txSel_r == 2'h2) ? 8'h18 : 8'h1E;
    wire [7:0] rxC = (rxSel_r == 2'h0) ? 8'h08 : (rxSel_r == 2'h1) ? 8'h10 :
                     (rxSel_r == 2'h2) ? 8'h38 : 8'h3C;
    wire [7:0] txC = (txSel_r == 2'h0) ? 8'h08 : (txSel_r == 2'h1) ? 8'h10 :
                     (txSel_r == 2'h2) ? 8'h20 : 8'h38;

    always_comb begin
        case (tbl)
            UFC_TBL_A: begin
                rxTrigger = rxA;
                txTrigger = 8'h01;
            end
            UFC_TBL_B: begin
                rxTrigger = rxB;
                txTrigger = txB;
            end
            UFC_TBL_C: begin
                rxTrigger = rxC;
                txTrigger = txC;
            end
            UFC_TBL_D: begin
                rxTrigger = trgRx_r;
                txTrigger = trgTx_r;
            end
            default: begin
                rxTrigger = rxA;
                txTrigger = 8'h01;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt generation

    assign rxReadyIrq = fifoEnable && (rxLevel >= rxTrigger);

    wire txFell  = (txLevel < txTrigger) && (txLevelPrev_r >= txTrigger);
    wire txEmpty = (txLevel == 8'h00) && (txLevelPrev_r != 8'h00) && !reloadOver_r;
    wire txEvent = fifoEnable ? (txFell || txEmpty) : (txEmpty || txFell);
    wire txNoFifoEmpty = !fifoEnable && (txLevel == 8'h00) && (txLevelPrev_r != 8'h00);

    assign txReadyIrq = txIrq_r;

    wire txIrqClr = rdIsr || wrThr;

    assign wakeIntEnable = wakeEn_r && enhancedEn;

    ////////////////////////////////////////////////////////////////////////////
    // status read value

    logic [5:0] srcCode;
    always_comb begin
        if (src.lineStatus) begin
            srcCode = 6'h06;
        end else if (src.rxTimeout) begin
            srcCode = 6'h0C;
        end else if (rxReadyIrq) begin
            srcCode = 6'h04;
        end else if (txIrq_r) begin
            srcCode = 6'h02;
        end else if (src.modemStatus) begin
            srcCode = 6'h00;
        end else if (matchIrq_r && enhancedEn) begin
            srcCode = 6'h10;
        end else if (src.flowPinRise && enhancedEn) begin
            srcCode = 6'h20;
        end else begin
            srcCode = 6'h01;
        end
    end

    wire [7:0] isrValue = {
        fifoEnable ^ (src.gpioPending && gpioIntEnable),
        fifoEnable,
        srcCode
    };
    wire [7:0] isrRead = {isrValue[6], isrValue[7], isrValue[5:0]};

    wire [7:0] rdSel = rdIsr ? isrRead : rdLcr ? lineCtl_r : 8'h00;

    // reads queue through the buffer so a stalled reader loses nothing
    logic bufInReady;
    assign reqReady = bufInReady;

    ufc_buf u_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (rdAny),
        .inReady  (bufInReady),
        .inData   (rdSel),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // line format

    assign lineFormat.wordBits = 4'h5 + {2'h0, lineCtl_r[1:0]};
    assign lineFormat.stopLong = lineCtl_r[2];
    assign lineFormat.stopHalf = lineCtl_r[2] && (lineCtl_r[1:0] == 2'h0);
    assign lineFormat.parityEn = lineCtl_r[3];
    assign lineFormat.parityEven = lineCtl_r[3] && !lineCtl_r[5] && lineCtl_r[4];
    assign lineFormat.parityForced = lineCtl_r[3] && lineCtl_r[5];
    assign lineFormat.parityVal = !lineCtl_r[4];

    assign fifoEnable  = fifoEn_r;
    assign rxFifoReset = rxRst_r;
    assign txFifoReset = txRst_r;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lineCtl_r <= `UFC_LCR_RESET;
            fifoEn_r  <= 1'b0;
            wakeEn_r  <= 1'b0;
            rxSel_r   <= 2'h0;
            txSel_r   <= 2'h0;
            trgRx_r   <= `UFC_TRG_RESET;
            trgTx_r   <= `UFC_TRG_RESET;
            lastAcc_r <= UFC_SEL_NONE;
        end else begin
            if (wrLcr) begin
                lineCtl_r <= req.wdata;
            end
            if (wrFcr) begin
                fifoEn_r <= req.wdata[`UFC_FCR_EN];
            end
            if (fcrTakes) begin
                wakeEn_r <= req.wdata[`UFC_FCR_WAKE];
                rxSel_r  <= req.wdata[`UFC_FCR_RXT_LO +: 2];
                if (enhancedEn) begin
                    txSel_r <= req.wdata[`UFC_FCR_TXT_LO +: 2];
                end else begin
                    txSel_r <= req.wdata[`UFC_FCR_RXT_LO +: 2];
                end
            end
            if (wrTrg && featureTrgTx) begin
                trgTx_r <= req.wdata;
            end
            if (wrTrg && !featureTrgTx) begin
                trgRx_r <= req.wdata;
            end
            lastAcc_r <= rdAny ? UFC_SEL_READ : req.wr ? UFC_SEL_WRITE : UFC_SEL_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxRst_r <= 1'b0;
            txRst_r <= 1'b0;
        end else begin
            rxRst_r <= fcrTakes && req.wdata[`UFC_FCR_RXRST];
            txRst_r <= fcrTakes && req.wdata[`UFC_FCR_TXRST];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txIrq_r       <= 1'b0;
            matchIrq_r    <= 1'b0;
            wakeIrq_r     <= 1'b0;
            reloadOver_r  <= 1'b0;
            txLevelPrev_r <= 8'h00;
        end else begin
            txLevelPrev_r <= txLevel;
            if (txLevel > txTrigger) begin
                reloadOver_r <= 1'b1;
            end else if (txLevel == 8'h00) begin
                reloadOver_r <= 1'b0;
            end
            // set wins over clear
            // status read clears
            txIrq_r    <= (txEvent || txNoFifoEmpty) || (txIrq_r && !txIrqClr);
            matchIrq_r <= src.charMatch || (matchIrq_r && !rdIsr);
            wakeIrq_r  <= (src.wakeUp && wakeIntEnable) || (wakeIrq_r && !rdIsr);
        end
    end
endmodule // ufc_core

// >>> ufc_core_properties.sv
/*
 * port assertions for the uart register control core.
 * assumes ufc_pkg and ufc_cfg.svh are compiled first; bound to every ufc_core.
 */
`timescale 1ns/100ps
`include "ufc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module ufc_core_properties (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire ufc_pkg::ufc_req_t req,
    input wire logic              rdValid,
    input wire logic              rdReady,
    input wire logic [7:0]        rdData,
    input wire logic              reqReady,
    input wire logic [1:0]        featureTable,
    input wire logic [7:0]        rxLevel,
    input wire logic              rxFifoReset,
    input wire logic              txFifoReset,
    input wire logic              fifoEnable,
    input wire logic [7:0]        rxTrigger,
    input wire logic [7:0]        txTrigger,
    input wire logic              rxReadyIrq,
    input wire ufc_pkg::ufc_fmt_t lineFormat
);
    import ufc_pkg::*;

    logic fcrWr;
    logic lcrWr;
    assign fcrWr = req.wr && req.addr == `UFC_OFF_ISR_FCR;
    assign lcrWr = req.wr && req.addr == `UFC_OFF_LCR;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_rx_flush: assert property (
        fcrWr && req.wdata[1:0] == 2'b11 |=> rxFifoReset ##1 !rxFifoReset)
        else $error("rx fifo reset is not a single pulse");
    chk_tx_flush: assert property (
        fcrWr && req.wdata[2] && req.wdata[0] |=> txFifoReset ##1 !txFifoReset)
        else $error("tx fifo reset is not a single pulse");
    chk_fcr_gate: assert property (
        fcrWr && !req.wdata[0] |=> !fifoEnable && !rxFifoReset && !txFifoReset)
        else $error("fifo control bits acted without enable");
    chk_fifo_on: assert property (fcrWr && req.wdata[0] |=> fifoEnable)
        else $error("fifo enable not set");
    chk_rx_irq: assert property (
        rxReadyIrq == (fifoEnable && rxLevel >= rxTrigger))
        else $error("receive interrupt disagrees with level");
    chk_table_a: assert property (featureTable == 2'b00 |->
        txTrigger == 8'h01 && rxTrigger inside {8'h01, 8'h04, 8'h08, 8'h0E})
        else $error("table a trigger out of set");
    chk_word_len: assert property (lcrWr |=>
        lineFormat.wordBits == 4'h5 + {2'b00, $past(req.wdata[1:0])})
        else $error("word length wrong");
    chk_parity_on: assert property (
        lcrWr |=> lineFormat.parityEn == $past(req.wdata[3]))
        else $error("parity enable wrong");
    // one cycle answer; the buffer keeps the word while the reader stalls
    chk_rd_answer: assert property (req.rd && reqReady |=> rdValid)
        else $error("read not answered");
    chk_rd_hold: assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
        else $error("read data lost under stall");
endmodule // ufc_core_properties

bind ufc_core ufc_core_properties chk (.core_clk, .rst, .req, .rdValid, .rdReady,
    .rdData, .reqReady, .featureTable, .rxLevel, .rxFifoReset, .txFifoReset,
    .fifoEnable, .rxTrigger, .txTrigger, .rxReadyIrq, .lineFormat);

// >>> ufc_host_model.sv
/*
 * host side reader of the core's read data, able to stall.
 * assumes the core clock and its synchronous reset.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module ufc_host_model (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        stall,
    input wire logic        rdValid,
    input wire logic [7:0]  rdData,
    output logic            rdReady,
    output logic [7:0]      gotData_r,
    output logic [15:0]     gotCount_r
);
    // a stalled host never takes, so every word must wait in the buffer
    assign rdReady = !stall;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gotCount_r <= 16'h0000;
            gotData_r  <= 8'h00;
        end else if (rdValid && rdReady) begin
            gotCount_r <= gotCount_r + 16'h0001;
            gotData_r  <= rdData;
        end
    end
endmodule // ufc_host_model

// >>> ufc_core_tb.sv
/*
 * self-checking bench of the uart register control core.
 * assumes the package, header, design and checker are compiled first.
 */
`timescale 1ns/100ps
`include "ufc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module ufc_core_tb;
    import ufc_pkg::*;

    logic core_clk, rst, rdValid, rdReady, reqReady, enhancedEn, featureTrgTx;
    logic gpioIntEnable, rxFifoReset, txFifoReset, fifoEnable, wakeIntEnable;
    logic rxReadyIrq, txReadyIrq, stall;
    logic [1:0] featureTable;
    logic [7:0] rdData, rxLevel, txLevel, rxTrigger, txTrigger, gotData;
    logic [15:0] gotCount;
    ufc_req_t req;
    ufc_src_t src;
    ufc_fmt_t lineFormat;
    int fails, check_count, cycles;
    logic [7:0] rxTbl [12] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h08, 8'h10, 8'h18, 8'h1C,
                               8'h08, 8'h10, 8'h38, 8'h3C};
    logic [7:0] txTbl [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08, 8'h18, 8'h1E,
                               8'h08, 8'h10, 8'h20, 8'h38};
    logic [6:0] srcTbl [5] = '{7'h40, 7'h20, 7'h10, 7'h04, 7'h50};
    logic [7:0] isrTbl [5] = '{8'hC6, 8'hCC, 8'hC0, 8'hE0, 8'hC6};

    ufc_core dut (.core_clk, .rst, .req, .rdValid, .rdReady, .rdData, .reqReady,
        .enhancedEn, .featureTable, .featureTrgTx, .gpioIntEnable, .src, .rxLevel,
        .txLevel, .rxFifoReset, .txFifoReset, .fifoEnable, .wakeIntEnable, .rxTrigger,
        .txTrigger, .rxReadyIrq, .txReadyIrq, .lineFormat);
    ufc_host_model host (.core_clk, .rst, .stall, .rdValid, .rdData, .rdReady,
        .gotData_r(gotData), .gotCount_r(gotCount));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic r, input logic w, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
        // one more edge so registered results have settled before any compare
        @(posedge core_clk);
    endtask

    // waits for the host to take the word, bounded so a lost read shows up
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
        int n;
        logic [15:0] c0;
        c0 = gotCount;
        put(1'b1, 1'b0, a, 8'h00);
        n = 0;
        while (gotCount == c0 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chk(gotData & m, exp);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, stall, featureTrgTx, gpioIntEnable} = 4'b1000;
        enhancedEn = 1'b1;
        featureTable = 2'b00;
        req = '0;
        src = '0;
        rxLevel = 8'h00;
        txLevel = 8'h40;
        fails = 0;
        check_count = 0;
        cycles = 0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd(`UFC_OFF_ISR_FCR, 8'h01, 8'hFF);
        rd(`UFC_OFF_LCR, 8'h00, 8'hFF);
        put(1'b0, 1'b1, `UFC_OFF_ISR_FCR, 8'h01);
        rd(`UFC_OFF_ISR_FCR, 8'hC1, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            src <= ufc_src_t'(srcTbl[i]);
            rd(`UFC_OFF_ISR_FCR, isrTbl[i], 8'hFF);
        end
        src <= '0;
        rxLevel <= 8'h01;
        rd(`UFC_OFF_ISR_FCR, 8'hC4, 8'hFF);
        rxLevel <= 8'h00;
        txLevel <= 8'h00;
        rd(`UFC_OFF_ISR_FCR, 8'hC2, 8'hFF);
        txLevel <= 8'h40;
        rd(`UFC_OFF_ISR_FCR, 8'hC1, 8'hFF);
        put(1'b0, 1'b0, 3'h0, 8'h00);
        src <= ufc_src_t'(7'h08);
        @(posedge core_clk);
        src <= '0;
        rd(`UFC_OFF_ISR_FCR, 8'hD0, 8'hFF);
        rd(`UFC_OFF_ISR_FCR, 8'hC1, 8'hFF);
        gpioIntEnable <= 1'b1;
        src <= ufc_src_t'(7'h01);
        rd(`UFC_OFF_ISR_FCR, 8'h80, 8'hC0);
        src <= '0;
        for (int t = 0; t < 3; t++) begin
            for (int c = 0; c < 4; c++) begin
                featureTable <= t[1:0];
                put(1'b0, 1'b1, `UFC_OFF_ISR_FCR, {c[1:0], c[1:0], 4'h1});
                chk(rxTrigger, rxTbl[t * 4 + c]);
                chk(txTrigger, txTbl[t * 4 + c]);
            end
        end
        featureTable <= 2'b11;
        put(1'b0, 1'b1, `UFC_OFF_TRG, 8'h20);
        featureTrgTx <= 1'b1;
        put(1'b0, 1'b1, `UFC_OFF_TRG, 8'h11);
        put(1'b0, 1'b1, `UFC_OFF_ISR_FCR, 8'hF1);
        chk(rxTrigger, 8'h20);
        chk(txTrigger, 8'h11);
        featureTable <= 2'b00;
        put(1'b0, 1'b1, `UFC_OFF_ISR_FCR, 8'h07);
        put(1'b0, 1'b1, `UFC_OFF_ISR_FCR, 8'h06);
        chk({7'h00, fifoEnable}, 8'h00);
        rd(`UFC_OFF_ISR_FCR, 8'h01, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            put(1'b0, 1'b1, `UFC_OFF_LCR, {6'h00, i[1:0]});
            rd(`UFC_OFF_LCR, {6'h00, i[1:0]}, 8'hFF);
        end
        put(1'b0, 1'b1, `UFC_OFF_LCR, 8'h04);
        chk({7'h00, lineFormat.stopHalf}, 8'h01);
        put(1'b0, 1'b1, `UFC_OFF_LCR, 8'h07);
        chk({6'h00, lineFormat.stopLong, lineFormat.stopHalf}, 8'h02);
        put(1'b0, 1'b1, `UFC_OFF_LCR, 8'h18);
        chk({5'h00, lineFormat.parityEn, lineFormat.parityForced,
             lineFormat.parityEven}, 8'h05);
        put(1'b0, 1'b1, `UFC_OFF_LCR, 8'h28);
        chk({6'h00, lineFormat.parityForced, lineFormat.parityVal}, 8'h03);
        put(1'b0, 1'b1, `UFC_OFF_LCR, 8'h38);
        chk({6'h00, lineFormat.parityForced, lineFormat.parityVal}, 8'h02);
        rd(3'h5, 8'h00, 8'hFF);
        stall <= 1'b1;
        put(1'b1, 1'b0, `UFC_OFF_LCR, 8'h00);
        put(1'b1, 1'b0, `UFC_OFF_LCR, 8'h00);
        chk({7'h00, reqReady}, 8'h00);
        stall <= 1'b0;
        repeat (4) @(posedge core_clk);
        // twenty plain reads plus the two taken after the stall
        chk(gotCount[7:0], 8'h16);
        chk(gotData, 8'h38);
        print_verdict();
    end
endmodule // ufc_core_tb
